// ==== cpmc_privilege_mode_control.sv ====
// Privilege level, mode, stack select and core register control
`timescale 1ns/10ps
`include "cpmc_defs.svh"
module cpmc_privilege_mode_control
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic excEntry,
   input wire logic excReturn,
   input wire logic setUser,
   input wire cpmc_pkg::cpmc_prot_t protAccess,
   input wire logic legacyInstr,
   input wire logic execStateWrite,
   input wire logic [31:0] execStateData,
   input wire cpmc_pkg::cpmc_regreq_t regReq,
   input wire logic [3:0] rdIdx,
   input wire cpmc_pkg::cpmc_bb_t bbReq,
   input wire logic [31:0] memRdata,
   input wire logic [31:0] dataAddr,
   input wire logic [1:0] dataSize,
   output logic privileged,
   output logic handlerMode,
   output logic useProcessStack,
   output logic accessFault,
   output logic [31:0] rdData,
   output logic [31:0] execStateReg,
   output logic [31:0] main_stack_pointer,
   output logic [31:0] process_stack_pointer,
   output logic bbLock,
   output logic bbWrEn,
   output logic [31:0] bbWordAddr,
   output logic [31:0] bbWdata,
   output logic [31:0] bbRdBit,
   output logic unalignedAccess
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   cpmc_pkg::cpmc_state_t state; // Current level and mode
   cpmc_pkg::cpmc_state_t savedState; // Thread state before first entry
   logic [8:0] nestDepth; // Exception nesting count
   logic [31:0] coreReg [0:15]; // Core registers
   logic bbPhase; // Bit-band write second phase
   logic [31:0] bbAddrHold; // Word address held across lock
   logic [4:0] bbBitHold; // Bit number held across lock
   logic bbValHold; // Bit value held across lock
   logic protHit; // Any protected access attempted
   logic next_fault; // Fault for this cycle
   logic [31:0] bbWord; // Word address of alias
   logic [4:0] bbBit; // Bit number of alias

   // Alias to word address decode, used twice
   function automatic logic [31:0] cpmc_bb_word(input logic [31:0] a);
      cpmc_bb_word = `CPMC_SRAM_BASE + {5'h0_0, a[24:5], 2'h0};
   endfunction : cpmc_bb_word

   assign protHit = protAccess.privInstr | protAccess.specialReg |
      protAccess.configReg | protAccess.debugReg;
   assign bbWord = cpmc_bb_word(bbReq.addr);
   assign bbBit = bbReq.addr[6:2];

   // ----------------------------------------
   // Level and mode tracking
   // ----------------------------------------
   // Only three legal states reachable
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= cpmc_pkg::CPMC_PRIV_THREAD;
         savedState <= cpmc_pkg::CPMC_PRIV_THREAD;
         nestDepth <= 9'h0_00;
      end
      else if (clkEn)
      begin
         if (excEntry)
         begin
            // Entry forces privileged handler, first entry saves thread state
            savedState <= (nestDepth == 9'h0_00) ? state : savedState; // RQ12
            state <= cpmc_pkg::CPMC_PRIV_HANDLER; // RQ4
            nestDepth <= nestDepth + 9'h0_01;
         end
         else if (excReturn && nestDepth != 9'h0_00)
         begin
            nestDepth <= nestDepth - 9'h0_01;
            // Last return restores thread state
            state <= (nestDepth == 9'h0_01) ? savedState : state; // RQ12
         end
         else
         begin
            case (state)
               // Privileged thread may drop to user
               cpmc_pkg::CPMC_PRIV_THREAD:
               begin
                  if (setUser)
                  begin
                     state <= cpmc_pkg::CPMC_USER_THREAD; // RQ1
                  end
               end
               // Handler stays privileged, user cannot raise itself
               cpmc_pkg::CPMC_PRIV_HANDLER, cpmc_pkg::CPMC_USER_THREAD:
               begin
                  state <= state; // RQ1
               end
               // Illegal code recovers privileged
               default:
               begin
                  state <= cpmc_pkg::CPMC_PRIV_THREAD;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Level, mode and stack selection
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         privileged <= 1'b1;
         handlerMode <= 1'b0;
         useProcessStack <= 1'b0;
      end
      else if (clkEn)
      begin
         privileged <= (state != cpmc_pkg::CPMC_USER_THREAD); // RQ1
         handlerMode <= (state == cpmc_pkg::CPMC_PRIV_HANDLER); // RQ4
         useProcessStack <= (state == cpmc_pkg::CPMC_USER_THREAD); // RQ10
      end
   end

   // ----------------------------------------
   // Fault detection
   // ----------------------------------------
   // Fault sources combined
   always_comb
   begin
      // User level protected access faults
      next_fault = (state == cpmc_pkg::CPMC_USER_THREAD) && protHit; // RQ2
      // Privileged access never faults (RQ3 by omission)
      // Legacy encodings and clearing the compact bit fault
      next_fault = next_fault || legacyInstr; // RQ8
      next_fault = next_fault || (execStateWrite && !execStateData[`CPMC_EXEC_BIT]); // RQ11
   end

   // Fault pulse register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         accessFault <= 1'b0;
      end
      else if (clkEn)
      begin
         accessFault <= next_fault; // RQ2 RQ3
      end
   end

   // ----------------------------------------
   // Execution-state register
   // ----------------------------------------
   // Compact bit forced to one
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         execStateReg <= `CPMC_RST_EXEC;
      end
      else if (clkEn && execStateWrite)
      begin
         execStateReg <= execStateData | `CPMC_RST_EXEC; // RQ11
      end
   end

   // ----------------------------------------
   // Core registers and banked stack
   // ----------------------------------------
   // Sixteen 32-bit registers, index 13 banked
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < `CPMC_NREG; i++)
         begin
            coreReg[i] <= `CPMC_RST_WORD; // RQ5
         end
         main_stack_pointer <= `CPMC_RST_WORD;
         process_stack_pointer <= `CPMC_RST_WORD;
      end
      else if (clkEn && regReq.wrEn)
      begin
         if (regReq.idx == `CPMC_SP_IDX)
         begin
            // Stack writes go to the active bank, word aligned
            if (state == cpmc_pkg::CPMC_USER_THREAD)
            begin
               process_stack_pointer <= regReq.wdata & `CPMC_SP_ALIGN_MASK; // RQ6 RQ10
            end
            else
            begin
               main_stack_pointer <= regReq.wdata & `CPMC_SP_ALIGN_MASK; // RQ6 RQ10
            end
         end
         else
         begin
            coreReg[regReq.idx] <= regReq.wdata; // RQ5
         end
      end
   end

   // Registered read port
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdData <= `CPMC_RST_WORD;
      end
      else if (clkEn)
      begin
         if (rdIdx == `CPMC_SP_IDX)
         begin
            rdData <= (state == cpmc_pkg::CPMC_USER_THREAD) ?
               process_stack_pointer : main_stack_pointer; // RQ10
         end
         else
         begin
            rdData <= coreReg[rdIdx];
         end
      end
   end

   // ----------------------------------------
   // Bit-band access
   // ----------------------------------------
   // Locked read then write back of one bit, lock dropped as the write pulse rises
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bbPhase <= 1'b0;
         bbLock <= 1'b0;
         bbWrEn <= 1'b0;
         bbWordAddr <= `CPMC_RST_WORD;
         bbWdata <= `CPMC_RST_WORD;
         bbRdBit <= `CPMC_RST_WORD;
         bbAddrHold <= `CPMC_RST_WORD;
         bbBitHold <= 5'h0_0;
         bbValHold <= 1'b0;
      end
      else if (clkEn)
      begin
         bbWrEn <= 1'b0;
         if (bbPhase)
         begin
            // Modify under lock, write pulse issued as the lock drops
            bbWdata <= (memRdata & ~(32'h0000_0001 << bbBitHold)) |
               ({31'h0000_0000, bbValHold} << bbBitHold); // RQ7
            bbWordAddr <= bbAddrHold;
            bbWrEn <= 1'b1;
            bbLock <= 1'b0;
            bbPhase <= 1'b0;
         end
         else if (bbReq.valid && bbReq.addr >= `CPMC_BB_BASE &&
            bbReq.addr <= `CPMC_BB_TOP)
         begin
            bbWordAddr <= bbWord;
            bbAddrHold <= cpmc_bb_word(bbReq.addr);
            bbBitHold <= bbBit;
            bbValHold <= bbReq.wbit;
            bbLock <= bbReq.write; // RQ7
            bbPhase <= bbReq.write;
         end
         bbRdBit <= {31'h0000_0000, memRdata[bbBitHold]}; // RQ7
      end
   end

   // ----------------------------------------
   // Unaligned access flag
   // ----------------------------------------
   // Unaligned accesses flagged, not faulted
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         unalignedAccess <= 1'b0;
      end
      else if (clkEn)
      begin
         unalignedAccess <= (dataSize == 2'h2 && dataAddr[1:0] != 2'h0) ||
            (dataSize == 2'h1 && dataAddr[0]); // RQ9
      end
   end
endmodule : cpmc_privilege_mode_control

// ==== cpmc_defs.svh ====
// Constants for the privilege and mode control block
// Contract
// RQ1: Handler mode exists only at privileged level
// RQ2: User level blocks protected access, raises fault
// RQ3: Privileged level permits all access, no fault
// RQ4: Handler while servicing exceptions, else thread
// RQ5: Sixteen core registers, each 32 bits wide
// RQ6: Separate main and process stack pointers
// RQ7: Bit-band SRAM accesses are atomic single-bit (lock here drops as the write pulse rises)
// RQ8: Compact instruction set only, legacy rejected
// RQ9: Unaligned accesses accepted, data stored contiguously
// RQ10: Process stack only in user thread
// RQ11: Execution-state compact bit stuck at one
// RQ12: Entry goes privileged handler, last return restores
`ifndef CPMC_DEFS_SVH
`define CPMC_DEFS_SVH
// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define CPMC_XLEN 32
`define CPMC_NREG 16
`define CPMC_RIDX_W 4
`define CPMC_SP_IDX 4'h0_d
`define CPMC_EXEC_BIT 24
`define CPMC_NEST_W 9
`define CPMC_SP_ALIGN_MASK 32'hFFFF_FFFC
`define CPMC_BB_BASE 32'h2200_0000
`define CPMC_BB_TOP 32'h23FF_FFFF
`define CPMC_SRAM_BASE 32'h2000_0000
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPMC_RST_WORD 32'h0000_0000
`define CPMC_RST_EXEC 32'h0100_0000
`endif

// ==== cpmc_pkg.sv ====
// Types for the privilege and mode control block
package cpmc_pkg;
   // ----------------------------------------
   // Operating state, Gray coded
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      CPMC_PRIV_THREAD = 2'h0,
      CPMC_PRIV_HANDLER = 2'h1,
      CPMC_USER_THREAD = 2'h3
   } cpmc_state_t;
   // Register file access request from pipeline
   typedef struct packed
   {
      logic wrEn;
      logic [3:0] idx;
      logic [31:0] wdata;
   } cpmc_regreq_t;
   // Protected access attempt flags
   typedef struct packed
   {
      logic privInstr;
      logic specialReg;
      logic configReg;
      logic debugReg;
   } cpmc_prot_t;
   // Bit-band request
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic wbit;
   } cpmc_bb_t;
endpackage : cpmc_pkg

// ==== cpmc_mode_asserts.sv ====
// Checker of mode, fault, stack and bit-band timing
`timescale 1ns/10ps
module cpmc_mode_asserts
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic excEntry,
   input wire cpmc_pkg::cpmc_prot_t protAccess,
   input wire logic legacyInstr,
   input wire logic execStateWrite,
   input wire logic [31:0] execStateData,
   input wire logic privileged,
   input wire logic handlerMode,
   input wire logic useProcessStack,
   input wire logic accessFault,
   input wire logic [31:0] execStateReg,
   input wire logic [31:0] process_stack_pointer,
   input wire logic bbLock,
   input wire logic bbWrEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_NO_USER_HANDLER: assert property (!(handlerMode && !privileged))
      else $error("handler mode at user level");
   AST_PSTACK_USER: assert property (useProcessStack == (!privileged && !handlerMode))
      else $error("wrong stack select");
   AST_ENTRY_HANDLER: assert property (excEntry && clkEn ##1 clkEn |=>
      handlerMode && privileged) else $error("entry not privileged handler");
   AST_LEGACY_FAULT: assert property (legacyInstr && clkEn |=> accessFault)
      else $error("legacy encoding without fault");
   AST_EXEC_FAULT: assert property (execStateWrite && !execStateData[24] && clkEn
      |=> accessFault) else $error("state bit clear without fault");
   AST_EXEC_BIT: assert property (execStateReg[24])
      else $error("state bit not one");
   AST_FAULT_CAUSE: assert property (accessFault && $past(clkEn) |-> $past(
      legacyInstr || (execStateWrite && !execStateData[24]) || (|protAccess)))
      else $error("fault without cause");
   AST_SP_ALIGN: assert property (process_stack_pointer[1:0] == 2'h0)
      else $error("process stack unaligned");
   AST_BB_WRITE: assert property (bbLock && clkEn |=> bbWrEn && !bbLock)
      else $error("bit-band write phase broken");
   // Main scenarios reached
   COV_ENTRY: cover property (handlerMode);
   COV_FAULT: cover property (accessFault);
   COV_BBWR: cover property (bbWrEn);
endmodule : cpmc_mode_asserts
bind cpmc_privilege_mode_control cpmc_mode_asserts chk (.clk, .nrst, .clkEn, .excEntry,
   .protAccess, .legacyInstr, .execStateWrite, .execStateData, .privileged, .handlerMode,
   .useProcessStack, .accessFault, .execStateReg, .process_stack_pointer, .bbLock, .bbWrEn);

// ==== cpmc_sram_model.sv ====
// Behavioural SRAM word answering bit-band accesses
`timescale 1ns/10ps
module cpmc_sram_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [31:0] wordAddr,
   input wire logic wrEn,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] memWord; // The one backed word
   // Other words read an inverted pattern, not stale data
   assign rdata = (wordAddr == 32'h2000_0000) ? memWord : ~memWord;
   // Store the modified word on the write pulse
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         memWord <= 32'h0000_0000;
      else if (wrEn)
         memWord <= wdata;
   end
endmodule : cpmc_sram_model

// ==== cpmc_privilege_mode_control_tb_top.sv ====
// Self-checking bench of privilege and mode control
`timescale 1ns/10ps
module cpmc_privilege_mode_control_tb_top;
   logic clk = 1'b0, nrst = 1'b0;
   logic clkEn = 1'b1; // Bench-driven clock enable
   logic sawFault; // Fault pulse caught in the cycle it stands
   // Pulses: entry, return, user, legacy, state write, four protected
   logic [8:0] ev = '0;
   logic [31:0] execStateData = '0, dataAddr = '0, memRdata;
   logic [1:0] dataSize = '0;
   logic [3:0] rdIdx = '0;
   cpmc_pkg::cpmc_regreq_t regReq = '0;
   cpmc_pkg::cpmc_bb_t bbReq = '0;
   logic privileged, handlerMode, useProcessStack, accessFault, bbLock, bbWrEn;
   logic unalignedAccess;
   logic [31:0] rdData, execStateReg, main_stack_pointer, process_stack_pointer;
   logic [31:0] bbWordAddr, bbWdata, bbRdBit;
   int failures = 0, n_checks = 0, cyc = 0;
   cpmc_privilege_mode_control uut (.clk, .nrst, .clkEn, .excEntry(ev[0]),
      .excReturn(ev[1]), .setUser(ev[2]), .protAccess(cpmc_pkg::cpmc_prot_t'(ev[8:5])),
      .legacyInstr(ev[3]), .execStateWrite(ev[4]), .execStateData, .regReq, .rdIdx,
      .bbReq, .memRdata, .dataAddr, .dataSize, .privileged, .handlerMode,
      .useProcessStack, .accessFault, .rdData, .execStateReg, .main_stack_pointer,
      .process_stack_pointer, .bbLock, .bbWrEn, .bbWordAddr, .bbWdata, .bbRdBit,
      .unalignedAccess);
   cpmc_sram_model sram (.clk, .nrst, .wordAddr(bbWordAddr), .wrEn(bbWrEn),
      .wdata(bbWdata), .rdata(memRdata));
   always #25 clk = ~clk;
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         failures++;
         close_out();
      end
   end
   task automatic settle;
      @(posedge clk);
      #1;
   endtask : settle
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One-cycle pulse; fault caught while it stands, status one edge later
   task automatic pulse(input logic [8:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 9'h000;
      #1;
      sawFault = accessFault;
      settle();
   endtask : pulse
   task automatic t_user;
      pulse(9'h004);
      chk(privileged, 0);
      chk(useProcessStack, 1);
      for (int i = 0; i < 4; i++)
      begin
         pulse(9'h020 << i);
         chk(sawFault, 1);
      end
      pulse(9'h001);
      chk({handlerMode, privileged, useProcessStack}, 3'h6);
      pulse(9'h020);
      chk(sawFault, 0);
      pulse(9'h001);
      pulse(9'h002);
      chk(handlerMode, 1);
      pulse(9'h002);
      chk({handlerMode, privileged, useProcessStack}, 3'h1);
      @(posedge clk) regReq <= '{1'b1, 4'hd, 32'h1234_5677};
      @(posedge clk) regReq <= '0;
      settle();
      chk(process_stack_pointer, 32'h1234_5674);
      chk(main_stack_pointer, 32'h0000_0000);
      $display("t_user done");
   endtask : t_user
   task automatic t_regs;
      @(posedge clk) regReq <= '{1'b1, 4'h3, 32'hA5A5_5A5A};
      @(posedge clk) regReq <= '0;
      rdIdx <= 4'h3;
      settle();
      chk(rdData, 32'hA5A5_5A5A);
      pulse(9'h008);
      chk(sawFault, 1);
      chk(accessFault, 0);
      pulse(9'h010);
      chk(sawFault, 1);
      chk(execStateReg, 32'h0100_0000);
      $display("t_regs done");
   endtask : t_regs
   // Clock enable low freezes level, mode and fault
   task automatic t_freeze;
      @(posedge clk) clkEn <= 1'b0;
      pulse(9'h009);
      chk({handlerMode, privileged, sawFault}, 3'h0);
      @(posedge clk) clkEn <= 1'b1;
      settle();
      chk({handlerMode, privileged, useProcessStack}, 3'h1);
      pulse(9'h008);
      chk(sawFault, 1);
      $display("t_freeze done");
   endtask : t_freeze
   task automatic t_bitband;
      @(posedge clk) bbReq <= '{1'b1, 1'b1, 32'h2200_0010, 1'b1};
      @(posedge clk) bbReq <= '0;
      #1;
      chk(bbWordAddr, 32'h2000_0000);
      settle();
      chk({bbWrEn, bbLock}, 2'h2);
      chk(bbWdata, 32'h0000_0010);
      settle();
      chk(bbWrEn, 1'b0);
      // Neighbour bit stays clear, written bit reads back set
      for (int b = 5; b >= 4; b--)
      begin
         @(posedge clk) bbReq <= '{1'b1, 1'b0, 32'h2200_0000 + 32'(b * 4), 1'b0};
         @(posedge clk) bbReq <= '0;
         settle();
         chk(bbRdBit, 32'(b == 4));
      end
      $display("t_bitband done");
   endtask : t_bitband
   task automatic t_unalign;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk) dataSize <= 2'(2 - i);
         dataAddr <= 32'h2000_0001 + 32'(i);
         settle();
         chk(unalignedAccess, 32'(i == 0));
      end
      $display("t_unalign done");
   endtask : t_unalign
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({privileged, handlerMode}, 2'h2);
      chk(execStateReg, 32'h0100_0000);
      t_user();
      t_regs();
      t_freeze();
      t_bitband();
      t_unalign();
      close_out();
   end
endmodule : cpmc_privilege_mode_control_tb_top
